/* File: awce_defines.svh */
// Offsets, opcodes, field positions and timing of the write command engine
`ifndef AWCE_DEFINES_SVH
`define AWCE_DEFINES_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define AWCE_OFF_CMD 8'h00
`define AWCE_OFF_DEVHD 8'h04
`define AWCE_OFF_ADRH 8'h08
`define AWCE_OFF_ADRM 8'h0C
`define AWCE_OFF_ADRL 8'h10
`define AWCE_OFF_CNT 8'h14
`define AWCE_OFF_FEAT 8'h18
`define AWCE_OFF_STAT 8'h1C
`define AWCE_OFF_ERR 8'h20
`define AWCE_OFF_DATA 8'h24
`define AWCE_OFF_MULT 8'h28
`define AWCE_OFF_IDENT 8'h2C
// ------------------------------------------------------------
// Opcodes and sub-operation codes
// ------------------------------------------------------------
`define AWCE_OP_WR_SEC 8'h30
`define AWCE_OP_WR_SEC_NE 8'h38
`define AWCE_OP_WR_MUL 8'hC5
`define AWCE_OP_WR_MUL_NE 8'hCD
`define AWCE_OP_SMART 8'hB0
`define AWCE_FT_RD_DATA 8'hD0
`define AWCE_FT_RD_THR 8'hD1
`define AWCE_FT_AUTOSAVE 8'hD2
`define AWCE_FT_SAVE 8'hD3
`define AWCE_FT_OFFLINE 8'hD4
`define AWCE_FT_ENABLE 8'hD8
`define AWCE_FT_DISABLE 8'hD9
`define AWCE_FT_STATUS 8'hDA
`define AWCE_SM_OK_LO 8'h4F
`define AWCE_SM_OK_HI 8'hC2
`define AWCE_SM_BAD_LO 8'hF4
`define AWCE_SM_BAD_HI 8'h2C
// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define AWCE_ST_BSY 7
`define AWCE_ST_DRDY 6
`define AWCE_ST_DRQ 3
`define AWCE_ST_ERR 0
`define AWCE_ER_MED 6
`define AWCE_ER_ABRT 2
`define AWCE_MULT_EN 8
`define AWCE_MAX_BLK 8'h01
`define AWCE_LAST_WORD 8'hFF
`define AWCE_FULL_COUNT 9'h100
`define AWCE_ONE_LEFT 9'h001
`define AWCE_HSIZE_WORD 3'b010
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define AWCE_CLK_NS 50
`define AWCE_BSY_MAX_NS 400
`define AWCE_BSY_MAX_CYC (`AWCE_BSY_MAX_NS / `AWCE_CLK_NS)
`define AWCE_PROG_NS 200
`define AWCE_PROG_CYC ((`AWCE_PROG_NS + `AWCE_CLK_NS - 1) / `AWCE_CLK_NS)
`endif

/* File: awce_pkg.sv */
// Types shared by the write command engine
package awce_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_XFER = 4'b0100,
        ST_PROG = 4'b1000
    } awce_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
        logic [7:0] addr;
    } awce_ahb_req_t;

    typedef struct packed {
        logic bsy;
        logic drq;
        logic err;
        logic abrt;
        logic mederr;
    } awce_flags_t;
endpackage

/* File: awce_top.sv */
// Task-file write command engine behind an AHB-Lite register slave
//
// Function
// - Opcode C5h is block write; busy rises within 400 ns of acceptance.
// - Block write interrupts once per block, not per sector.
// - Data-request qualifies only the start of each block.
// - Count is sectors; whole blocks, then one partial block of the remainder.
// - Block write aborts when block size unset or block writes disabled.
// - Block write error stops at failing sector; no further blocks.
// - Interrupt whenever data-request rises at each block start.
// - After error: address is failing sector, count holds sectors remaining.
// - Only block size one is supported and advertised.
// - Opcode CDh is block write without erase, same protocol.
// - Opcode 30h writes 1 to 256 sectors; zero count means 256.
// - Start address comes from task file, 28-bit logical layout.
// - Sector write: busy, then data-request, no interrupt for first sector.
// - After each sector: busy, no data-request; next ready raises interrupt.
// - After last sector busy holds until completion, then interrupt.
// - Multi-sector error stops at failing sector, address kept.
// - Opcode 38h is sector write without erase, same protocol.
// - Monitoring command picks its sub-operation from the feature code.
// - Unsupported feature code aborts the monitoring command.
// - Return status loads F4h/2Ch when spares low, else 4Fh/C2h.
// - A sector is 512 bytes moved as 16-bit words.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "awce_defines.svh"

module awce_top (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic media_err_i,
    input wire logic spare_low_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic intrq_o,
    output logic [15:0] media_wdata_o,
    output logic media_wvalid_o,
    output awce_pkg::awce_flags_t flags_o
);
    import awce_pkg::*;

    localparam int BSY_CYC = `AWCE_BSY_MAX_CYC;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_wr(input logic [7:0] op);
        return (op == `AWCE_OP_WR_SEC) || (op == `AWCE_OP_WR_SEC_NE) ||
               (op == `AWCE_OP_WR_MUL) || (op == `AWCE_OP_WR_MUL_NE);
    endfunction

    function automatic logic is_mul(input logic [7:0] op);
        return (op == `AWCE_OP_WR_MUL) || (op == `AWCE_OP_WR_MUL_NE);
    endfunction

    function automatic logic smart_ok(input logic [7:0] f);
        return (f == `AWCE_FT_RD_DATA) || (f == `AWCE_FT_RD_THR) ||
               (f == `AWCE_FT_AUTOSAVE) || (f == `AWCE_FT_SAVE) ||
               (f == `AWCE_FT_OFFLINE) || (f == `AWCE_FT_ENABLE) ||
               (f == `AWCE_FT_DISABLE) || (f == `AWCE_FT_STATUS);
    endfunction

    function automatic logic [7:0] blk_len(input logic [8:0] rem, input logic [7:0] bl);
        return ({1'b0, bl} < rem) ? bl : rem[7:0];
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    awce_ahb_req_t req_q;
    awce_state_t state_q;
    awce_flags_t flags_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata_d;
    logic intrq_q;
    logic [7:0] cmd_q, devhd_q, addrh_q, addrm_q, addrl_q, count_q, feat_q;
    logic [7:0] mult_q;
    logic mult_en_q;
    logic [8:0] rem_q;
    logic [7:0] word_q, xsec_q, psec_q, blklen_q, blkcnt_q;
    logic [3:0] prog_cnt_q;
    logic [15:0] wdata_q;
    logic wvalid_q;
    logic accept, wr_en, rd_cyc, st_rd;
    logic cmd_go, data_wr, sec_in, blk_end, prog_done, sec_ok, sec_bad;
    logic last_sec, adv_addr, smart_ld, setup_abort, wr_start, idle;
    logic [27:0] lba;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    assign accept = hsel_i & htrans_i[1] & hready_i;
    assign wr_en = req_q.valid & req_q.write & req_q.hit;
    assign rd_cyc = req_q.valid & ~req_q.write & ~hreadyout_q;
    assign st_rd = rd_cyc & req_q.hit & (req_q.addr == `AWCE_OFF_STAT);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_q <= '0;
        end else if (hready_i) begin
            req_q.valid <= accept;
            req_q.write <= hwrite_i;
            req_q.hit <= (haddr_i[31:8] == 24'h000000) && (hsize_i == `AWCE_HSIZE_WORD);
            req_q.addr <= haddr_i[7:0];
        end
    end

    // Reads take one wait state so read data comes from a flop
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hreadyout_q <= 1'b1;
        end else if (accept && !hwrite_i) begin
            hreadyout_q <= 1'b0;
        end else if (!hreadyout_q) begin
            hreadyout_q <= 1'b1;
        end
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (req_q.hit) begin
            case (req_q.addr)
                `AWCE_OFF_DEVHD: rdata_d[7:0] = devhd_q;
                `AWCE_OFF_ADRH: rdata_d[7:0] = addrh_q;
                `AWCE_OFF_ADRM: rdata_d[7:0] = addrm_q;
                `AWCE_OFF_ADRL: rdata_d[7:0] = addrl_q;
                `AWCE_OFF_CNT: rdata_d[7:0] = count_q;
                `AWCE_OFF_STAT: begin
                    rdata_d[`AWCE_ST_BSY] = flags_q.bsy;
                    rdata_d[`AWCE_ST_DRDY] = ~flags_q.bsy;
                    rdata_d[`AWCE_ST_DRQ] = flags_q.drq;
                    rdata_d[`AWCE_ST_ERR] = flags_q.err;
                end
                `AWCE_OFF_ERR: begin
                    rdata_d[`AWCE_ER_MED] = flags_q.mederr;
                    rdata_d[`AWCE_ER_ABRT] = flags_q.abrt;
                end
                `AWCE_OFF_MULT: rdata_d[`AWCE_MULT_EN:0] = {mult_en_q, mult_q};
                `AWCE_OFF_IDENT: rdata_d[7:0] = `AWCE_MAX_BLK;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_cyc) begin
            hrdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Engine strobes
    // ------------------------------------------------------------
    assign idle = (state_q == ST_IDLE);
    assign cmd_go = wr_en & idle & (req_q.addr == `AWCE_OFF_CMD);
    assign data_wr = wr_en & flags_q.drq & (req_q.addr == `AWCE_OFF_DATA);
    assign sec_in = data_wr & (word_q == `AWCE_LAST_WORD);
    assign blk_end = sec_in & ((xsec_q + 8'h01) == blkcnt_q);
    assign prog_done = (state_q == ST_PROG) & (prog_cnt_q == 4'(`AWCE_PROG_CYC - 1));
    assign sec_ok = prog_done & ~media_err_i;
    assign sec_bad = prog_done & media_err_i;
    assign last_sec = (rem_q == `AWCE_ONE_LEFT);
    assign adv_addr = sec_ok & ~last_sec;
    assign smart_ld = (state_q == ST_SETUP) & (cmd_q == `AWCE_OP_SMART) &
                      (feat_q == `AWCE_FT_STATUS);
    assign lba = {devhd_q[3:0], addrh_q, addrm_q, addrl_q} + 28'h0000001;

    always_comb begin
        setup_abort = 1'b0;
        if (state_q == ST_SETUP) begin
            if (is_wr(cmd_q)) begin
                setup_abort = is_mul(cmd_q) & (~mult_en_q | (mult_q == 8'h00));
            end else if (cmd_q == `AWCE_OP_SMART) begin
                setup_abort = ~smart_ok(feat_q);
            end else begin
                setup_abort = 1'b1;
            end
        end
    end

    assign wr_start = (state_q == ST_SETUP) & is_wr(cmd_q) & ~setup_abort;

    // ------------------------------------------------------------
    // Task file
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_q <= 8'h00;
            devhd_q <= 8'h00;
            addrh_q <= 8'h00;
            addrm_q <= 8'h00;
            addrl_q <= 8'h00;
            count_q <= 8'h00;
            feat_q <= 8'h00;
            mult_q <= 8'h00;
            mult_en_q <= 1'b0;
        end else if (wr_en && idle) begin
            case (req_q.addr)
                `AWCE_OFF_CMD: cmd_q <= hwdata_i[7:0];
                `AWCE_OFF_DEVHD: devhd_q <= hwdata_i[7:0];
                `AWCE_OFF_ADRH: addrh_q <= hwdata_i[7:0];
                `AWCE_OFF_ADRM: addrm_q <= hwdata_i[7:0];
                `AWCE_OFF_ADRL: addrl_q <= hwdata_i[7:0];
                `AWCE_OFF_CNT: count_q <= hwdata_i[7:0];
                `AWCE_OFF_FEAT: feat_q <= hwdata_i[7:0];
                `AWCE_OFF_MULT: begin
                    // Unsupported sizes leave block writes unset
                    mult_q <= (hwdata_i[7:0] <= `AWCE_MAX_BLK) ? hwdata_i[7:0] : 8'h00;
                    mult_en_q <= hwdata_i[`AWCE_MULT_EN];
                end
                default: cmd_q <= cmd_q;
            endcase
        end else if (smart_ld) begin
            addrm_q <= spare_low_i ? `AWCE_SM_BAD_LO : `AWCE_SM_OK_LO;
            addrh_q <= spare_low_i ? `AWCE_SM_BAD_HI : `AWCE_SM_OK_HI;
        end else if (sec_ok) begin
            count_q <= count_q - 8'h01;
            if (adv_addr) begin
                {devhd_q[3:0], addrh_q, addrm_q, addrl_q} <= lba;
            end
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_go) begin
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    state_q <= wr_start ? ST_XFER : ST_IDLE;
                end
                ST_XFER: begin
                    if (blk_end) begin
                        state_q <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    if (sec_bad || (sec_ok && last_sec)) begin
                        state_q <= ST_IDLE;
                    end else if (sec_ok && psec_q == 8'h01) begin
                        state_q <= ST_XFER;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_q <= '0;
        end else if (cmd_go) begin
            flags_q <= '0;
            flags_q.bsy <= 1'b1;
        end else if (setup_abort) begin
            flags_q.bsy <= 1'b0;
            flags_q.err <= 1'b1;
            flags_q.abrt <= 1'b1;
        end else if (state_q == ST_SETUP) begin
            flags_q.bsy <= 1'b0;
            flags_q.drq <= wr_start;
        end else if (blk_end) begin
            flags_q.bsy <= 1'b1;
            flags_q.drq <= 1'b0;
        end else if (sec_bad) begin
            flags_q.bsy <= 1'b0;
            flags_q.err <= 1'b1;
            flags_q.mederr <= 1'b1;
        end else if (sec_ok && last_sec) begin
            flags_q.bsy <= 1'b0;
        end else if (sec_ok && psec_q == 8'h01) begin
            flags_q.bsy <= 1'b0;
            flags_q.drq <= 1'b1;
        end
    end

    // Set wins over the clear from a status read
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            intrq_q <= 1'b0;
        end else if (setup_abort || (state_q == ST_SETUP && cmd_q == `AWCE_OP_SMART)) begin
            intrq_q <= 1'b1;
        end else if (wr_start) begin
            intrq_q <= is_mul(cmd_q);
        end else if (sec_bad || (sec_ok && (last_sec || psec_q == 8'h01))) begin
            intrq_q <= 1'b1;
        end else if (cmd_go || st_rd) begin
            intrq_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sector and block counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rem_q <= 9'h000;
            blklen_q <= 8'h00;
            blkcnt_q <= 8'h00;
            xsec_q <= 8'h00;
            psec_q <= 8'h00;
            word_q <= 8'h00;
            prog_cnt_q <= 4'h0;
        end else if (wr_start) begin
            rem_q <= (count_q == 8'h00) ? `AWCE_FULL_COUNT : {1'b0, count_q};
            blklen_q <= is_mul(cmd_q) ? mult_q : `AWCE_MAX_BLK;
            blkcnt_q <= blk_len((count_q == 8'h00) ? `AWCE_FULL_COUNT : {1'b0, count_q},
                                is_mul(cmd_q) ? mult_q : `AWCE_MAX_BLK);
            xsec_q <= 8'h00;
            word_q <= 8'h00;
        end else if (data_wr) begin
            word_q <= word_q + 8'h01;
            if (blk_end) begin
                xsec_q <= 8'h00;
                psec_q <= blkcnt_q;
                prog_cnt_q <= 4'h0;
            end else if (sec_in) begin
                xsec_q <= xsec_q + 8'h01;
            end
        end else if (state_q == ST_PROG) begin
            prog_cnt_q <= prog_done ? 4'h0 : prog_cnt_q + 4'h1;
            if (sec_ok) begin
                rem_q <= rem_q - 9'h001;
                psec_q <= psec_q - 8'h01;
                if (psec_q == 8'h01) begin
                    blkcnt_q <= blk_len(rem_q - 9'h001, blklen_q);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Media write port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdata_q <= 16'h0000;
            wvalid_q <= 1'b0;
        end else begin
            wvalid_q <= data_wr;
            if (data_wr) begin
                wdata_q <= hwdata_i[15:0];
            end
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hreadyout_q;
    assign hresp_o = 1'b0;
    assign intrq_o = intrq_q;
    assign media_wdata_o = wdata_q;
    assign media_wvalid_o = wvalid_q;
    assign flags_o = flags_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_blk_start;
        wr_start && is_mul(cmd_q);
    endsequence

    sequence s_prog_fail;
        prog_done && media_err_i;
    endsequence

    sequence s_final_hold;
        (flags_q.bsy && !flags_q.drq && state_q == ST_PROG)[*4];
    endsequence

    a_bsy_window: assert property (cmd_go |-> ##[1:BSY_CYC] flags_q.bsy)
        else $error("busy not raised in time");
    a_blk_int: assert property (s_blk_start |=> intrq_q && flags_q.drq)
        else $error("no interrupt at block start");
    a_first_quiet: assert property ((wr_start && !is_mul(cmd_q)) |=>
        flags_q.drq && !flags_q.bsy && !intrq_q)
        else $error("first sector handshake wrong");
    a_mul_abort: assert property ((state_q == ST_SETUP && is_mul(cmd_q) &&
        (!mult_en_q || mult_q == 8'h00)) |=> flags_q.abrt && !flags_q.bsy && intrq_q)
        else $error("unset block write not aborted");
    a_blk_drq_held: assert property ((sec_in && !blk_end) |=>
        flags_q.drq && !flags_q.bsy)
        else $error("data request dropped inside block");
    a_sector_busy: assert property (blk_end |=> flags_q.bsy && !flags_q.drq)
        else $error("busy not set after block");
    a_final_busy: assert property ((blk_end && rem_q == `AWCE_ONE_LEFT) |=>
        s_final_hold ##1 (!flags_q.bsy && intrq_q && state_q == ST_IDLE))
        else $error("completion sequence wrong");
    a_err_stop: assert property (s_prog_fail |=> flags_q.err && !flags_q.bsy &&
        $stable(addrl_q) && $stable(count_q) && state_q == ST_IDLE)
        else $error("error did not stop at sector");
    a_zero_full: assert property ((wr_start && count_q == 8'h00) |=>
        rem_q == `AWCE_FULL_COUNT)
        else $error("zero count not taken as full");
    a_smart_reject: assert property ((state_q == ST_SETUP &&
        cmd_q == `AWCE_OP_SMART && !smart_ok(feat_q)) |=> flags_q.abrt)
        else $error("bad feature code not aborted");
    a_smart_alarm: assert property ((smart_ld && spare_low_i) |=>
        addrm_q == `AWCE_SM_BAD_LO && addrh_q == `AWCE_SM_BAD_HI)
        else $error("threshold status not loaded");
endmodule

/* File: awce_host.sv */
// AHB-Lite host model driving the task-file registers
`timescale 1ns/1ps
module awce_host (
    input wire logic clk_sys_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    initial begin
        {hsel_o, haddr_o, htrans_o, hwrite_o, hsize_o, hwdata_o} = '0;
    end
    // One single word transfer; caller stands just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o <= 1'b1;
        htrans_o <= 2'b10;
        hwrite_o <= w;
        haddr_o <= {24'h000000, a};
        hsize_o <= 3'b010;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        htrans_o <= 2'b00;
        hwdata_o <= d;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask
    // One sector of 256 words, sent back to back without checking drq
    task automatic sector();
        logic [31:0] q;
        for (int i = 0; i < 256; i++) begin
            xfer(1'b1, 8'h24, 32'h0000A500 + i, q);
        end
    endtask
endmodule

/* File: tb_awce_top.sv */
// Self-checking bench for the write command engine
`timescale 1ns/1ps
`include "awce_defines.svh"
module tb_awce_top;
    import awce_pkg::*;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, media_err = 1'b0, spare_low = 1'b0;
    logic hsel, hwrite, hready, hresp, intrq, wvalid;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [15:0] wdata;
    awce_flags_t flags;
    int error_cnt = 0, compares = 0, words = 0;
    logic [7:0] sc [9] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hD9, 8'hDA, 8'hD5};
    logic [7:0] op2 [2];
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (wvalid === 1'b1) words++;
    awce_host awce_host_i (.clk_sys_i(clk_sys_i), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));
    awce_top awce_top_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .media_err_i(media_err),
        .spare_low_i(spare_low), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .intrq_o(intrq), .media_wdata_o(wdata), .media_wvalid_o(wvalid), .flags_o(flags));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        awce_host_i.xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awce_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] ft);
        wr(`AWCE_OFF_DEVHD, 32'hE1);
        wr(`AWCE_OFF_ADRH, 32'h23);
        wr(`AWCE_OFF_ADRM, 32'h45);
        wr(`AWCE_OFF_ADRL, 32'h56);
        wr(`AWCE_OFF_CNT, cnt);
        wr(`AWCE_OFF_FEAT, ft);
        wr(`AWCE_OFF_CMD, op);
    endtask
    // Bounded wait on {bsy,drq,err,abrt,mederr}
    task automatic await(input logic [4:0] m, input logic [4:0] v);
        int n;
        // Skip the edge that launched the request; flags there are stale
        @(negedge clk_sys_i);
        for (n = 0; n < 50 && (flags & m) !== v; n++) @(negedge clk_sys_i);
        chk("flags", v, flags & m);
        @(posedge clk_sys_i);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(`AWCE_OFF_STAT, 32'h40, "status");
        rd(`AWCE_OFF_IDENT, 32'h01, "ident");
        rd(8'hFC, 32'h0, "unmapped");
        wr(`AWCE_OFF_MULT, 32'h105);
        rd(`AWCE_OFF_MULT, 32'h100, "mult");
        op2 = '{8'h30, 8'h38};
        foreach (op2[k]) begin
            cmd(op2[k], 8'h02, 8'h00);
            await(5'b11000, 5'b01000);
            chk("intrq", 1'b0, intrq);
            awce_host_i.sector();
            await(5'b11000, 5'b01000);
            chk("intrq", 1'b1, intrq);
            chk("wdata", 32'hA5FF, wdata);
            rd(`AWCE_OFF_ADRL, 32'h57, "adrl");
            rd(`AWCE_OFF_CNT, 32'h01, "cnt");
            awce_host_i.sector();
            await(5'b11000, 5'b00000);
            chk("intrq", 1'b1, intrq);
            rd(`AWCE_OFF_CNT, 32'h0, "cnt");
            rd(`AWCE_OFF_STAT, 32'h40, "status");
        end
        chk("words", 1024, words);
        cmd(8'h30, 8'h00, 8'h00);
        await(5'b11000, 5'b01000);
        awce_host_i.sector();
        await(5'b11000, 5'b01000);
        rd(`AWCE_OFF_CNT, 32'hFF, "cnt");
        media_err <= 1'b1;
        awce_host_i.sector();
        await(5'b10000, 5'b00000);
        media_err <= 1'b0;
        rd(`AWCE_OFF_CNT, 32'hFF, "cnt");
        rd(`AWCE_OFF_ADRL, 32'h57, "adrl");
        cmd(8'hC5, 8'h01, 8'h00);
        await(5'b10000, 5'b00000);
        rd(`AWCE_OFF_ERR, 32'h04, "error");
        wr(`AWCE_OFF_MULT, 32'h001);
        cmd(8'hC5, 8'h01, 8'h00);
        await(5'b10000, 5'b00000);
        rd(`AWCE_OFF_ERR, 32'h04, "error");
        wr(`AWCE_OFF_MULT, 32'h101);
        op2 = '{8'hC5, 8'hCD};
        foreach (op2[k]) begin
            cmd(op2[k], 8'h02, 8'h00);
            await(5'b11000, 5'b01000);
            chk("intrq", 1'b1, intrq);
            rd(`AWCE_OFF_STAT, 32'h48, "status");
            awce_host_i.sector();
            await(5'b11000, 5'b01000);
            chk("intrq", 1'b1, intrq);
            media_err <= 1'b1;
            awce_host_i.sector();
            await(5'b10000, 5'b00000);
            media_err <= 1'b0;
            rd(`AWCE_OFF_ERR, 32'h40, "error");
            rd(`AWCE_OFF_CNT, 32'h01, "cnt");
            rd(`AWCE_OFF_ADRL, 32'h57, "adrl");
        end
        foreach (sc[k]) begin
            cmd(8'hB0, 8'h00, sc[k]);
            await(5'b10000, 5'b00000);
            rd(`AWCE_OFF_ERR, (k < 8) ? 32'h0 : 32'h04, "error");
        end
        spare_low <= 1'b1;
        cmd(8'hB0, 8'h00, 8'hDA);
        await(5'b10000, 5'b00000);
        rd(`AWCE_OFF_ADRM, 32'hF4, "adrm");
        rd(`AWCE_OFF_ADRH, 32'h2C, "adrh");
        spare_low <= 1'b0;
        cmd(8'hB0, 8'h00, 8'hDA);
        await(5'b10000, 5'b00000);
        rd(`AWCE_OFF_ADRM, 32'h4F, "adrm");
        rd(`AWCE_OFF_ADRH, 32'hC2, "adrh");
        complete_run();
    end
endmodule
